// File: src/inhib_logic.sv
/*
  Inhibit input logic: two debounced switch channels acting on traction and
  auxiliary outputs, with direction and tiller switch options, behind APB.
  Assumes switch pins are asynchronous and that power-on asserts i_nrst.
*/
// What this block does
// RULE1: Input accepted after stable for programmed debounce.
// RULE2: Zero debounce uses built-in default filter.
// RULE3: Mode selects disabled, pulled low or floating.
// RULE4: Active inhibit acts on selected target.
// RULE5: Forward plus reverse inhibits all traction.
// RULE6: Traction inhibit caps speed at programmed limit.
// RULE7: Zero limit makes a true inhibit.
// RULE8: Nonzero limit only limits speed.
// RULE9: Operation setting ignored unless limit zero.
// RULE10: Latched inhibit held until reset after release.
// RULE11: Non-latched inhibit clears when condition removed.
// RULE12: Latched activation flashes six bars, logs trip.
// RULE13: Speed limit decelerates, indicator unchanged.
// RULE14: Zero limit traction inhibit prevents drive.
// RULE15: Input two targeting aux two switches it.
// RULE16: Direction option makes pin one forward switch.
// RULE17: Tiller option makes pin two drive enable.
// RULE18: Two independent channels, five settings each.
// RULE19: Aux two alarm or brake mode ignores target.
// RULE20: Debounce timer restarts on change; reset clears latch.
`timescale 1ns/1ps
`include "inhib_defines.svh"

module inhib_logic #(
  parameter int STEP_CYC = `INHIB_STEP_CYC,
  parameter int DFLT_CYC = `INHIB_DFLT_DB_CYC
) (
  input  wire logic        i_clock,
  input  wire logic        i_nrst,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [11:0] i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic             o_pready,
  output logic [31:0]      o_prdata,
  output logic             o_pslverr,
  input  wire logic [1:0]  i_pin,
  input  wire logic        i_throttle_demand,
  output logic             o_fwd_allow,
  output logic             o_rev_allow,
  output logic [6:0]       o_speed_cap,
  output logic [2:0]       o_aux_inhibit,
  output logic             o_aux2_switch,
  output logic             o_trip_flash,
  output logic             o_trip_log
);
  initial begin
    if (STEP_CYC < 1 || DFLT_CYC < 1 || DFLT_CYC > STEP_CYC)
      $error("inhib_logic: bad timing parameters.");
  end

  function automatic logic [31:0] max_cyc(input logic [3:0] steps);
    max_cyc = (steps == 4'h0) ? 32'(DFLT_CYC) : 32'(STEP_CYC) * 32'(steps);
  endfunction : max_cyc

  logic [31:0] cfg_reg [2];
  logic [3:0]  ctrl_reg;
  logic [1:0]  sync1_reg;
  logic [1:0]  sync2_reg;
  logic [1:0]  stable_reg;
  logic [31:0] cnt_reg [2];
  logic [1:0]  latch_reg;
  logic [1:0]  active;
  logic [1:0]  hard;
  logic [1:0]  trip_rise;
  logic [1:0]  latched_next;
  logic        inh_fwd;
  logic        inh_rev;
  logic [6:0]  cap_next;
  logic [2:0]  aux_next;
  logic        fwd_next;
  logic        rev_next;
  logic        acc;

  assign acc = i_psel && i_penable;

  // APB slave: zero wait states; unmapped addresses answer with an error.
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      cfg_reg[0] <= `INHIB_CFG_RST;
      cfg_reg[1] <= `INHIB_CFG_RST;
      ctrl_reg   <= `INHIB_CTRL_RST;
    end else if (acc && i_pwrite) begin
      case (i_paddr)
        `INHIB_OFF_CFG0: cfg_reg[0] <= i_pwdata; // [RULE18]
        `INHIB_OFF_CFG1: cfg_reg[1] <= i_pwdata; // [RULE18]
        `INHIB_OFF_CTRL: ctrl_reg <= i_pwdata[3:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      o_pready  <= 1'b0;
      o_prdata  <= 32'h0;
      o_pslverr <= 1'b0;
    end else begin
      o_pready  <= i_psel && !i_penable;
      o_pslverr <= 1'b0;
      if (i_psel && !i_penable) begin
        o_prdata <= 32'h0;
        case (i_paddr)
          `INHIB_OFF_CFG0: o_prdata <= cfg_reg[0];
          `INHIB_OFF_CFG1: o_prdata <= cfg_reg[1];
          `INHIB_OFF_CTRL: o_prdata <= {28'h0, ctrl_reg};
          `INHIB_OFF_STAT: o_prdata <= {24'h0, 2'h0, latch_reg, active, stable_reg};
          default: o_pslverr <= 1'b1;
        endcase
      end
    end
  end

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      sync1_reg <= 2'h3;
      sync2_reg <= 2'h3;
    end else begin
      sync1_reg <= i_pin;
      sync2_reg <= sync1_reg;
    end
  end

  // Debounce per channel; any bounce restarts the count. [RULE20]
  for (genvar c = 0; c < 2; c++) begin : g_db
    logic [3:0] steps;
    assign steps = (cfg_reg[c][`INHIB_F_DB_LSB +: 4] > `INHIB_DB_MAX) ?
                   `INHIB_DB_MAX : cfg_reg[c][`INHIB_F_DB_LSB +: 4];
    always_ff @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) begin
        cnt_reg[c]    <= 32'h0;
        stable_reg[c] <= 1'b1;
      end else if (sync2_reg[c] == stable_reg[c]) begin
        cnt_reg[c] <= 32'h0; // [RULE20]
      end else if (cnt_reg[c] + 32'h1 >= max_cyc(steps)) begin
        cnt_reg[c]    <= 32'h0;
        stable_reg[c] <= sync2_reg[c]; // [RULE1] [RULE2]
      end else begin
        cnt_reg[c] <= cnt_reg[c] + 32'h1;
      end
    end

    logic [1:0] mode;
    logic       opt_sw;
    assign mode   = cfg_reg[c][`INHIB_F_MODE_LSB +: 2];
    assign opt_sw = (c == 0) ? ctrl_reg[`INHIB_C_DIRSW_BIT] : ctrl_reg[`INHIB_C_TILLER_BIT];
    always_comb begin
      case (inhib_pkg::inhib_mode_t'(mode))
        inhib_pkg::INHIB_MODE_LOW:  active[c] = !stable_reg[c] && !opt_sw; // [RULE3]
        inhib_pkg::INHIB_MODE_OPEN: active[c] = stable_reg[c] && !opt_sw; // [RULE3]
        default:                    active[c] = 1'b0;
      endcase
    end
    logic [4:0] tgt;
    assign tgt     = cfg_reg[c][`INHIB_F_TGT_LSB +: 5];
    assign hard[c] = active[c] && (tgt[0] || tgt[1]) &&
                     (cfg_reg[c][`INHIB_F_SPD_LSB +: 7] == 7'h0); // [RULE7] [RULE8]
    assign trip_rise[c] = hard[c] && cfg_reg[c][`INHIB_F_OPL_BIT]; // [RULE9]
    // Latch holds until i_nrst is asserted, whether or not the input is released. [RULE10]
    assign latched_next[c] = latch_reg[c] | trip_rise[c];
  end

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      latch_reg <= 2'h0; // [RULE20]
    end else begin
      latch_reg <= latched_next; // [RULE10]
    end
  end

  always_comb begin
    logic [4:0] t;
    logic [6:0] s;
    t        = 5'h0;
    s        = 7'h0;
    inh_fwd  = 1'b0;
    inh_rev  = 1'b0;
    cap_next = `INHIB_SPD_MAX;
    aux_next = 3'h0;
    for (int c = 0; c < 2; c++) begin
      if (active[c] || latch_reg[c]) begin
        t = cfg_reg[c][`INHIB_F_TGT_LSB +: 5];
        s = (cfg_reg[c][`INHIB_F_SPD_LSB +: 7] > `INHIB_SPD_MAX) ?
            `INHIB_SPD_MAX : cfg_reg[c][`INHIB_F_SPD_LSB +: 7];
        if (s == 7'h0 && (t[0] || t[1])) begin
          inh_fwd = inh_fwd | t[0]; // [RULE4] [RULE5] [RULE11] [RULE14]
          inh_rev = inh_rev | t[1]; // [RULE4] [RULE5] [RULE14]
        end else if ((t[0] || t[1]) && s < cap_next && active[c]) begin
          cap_next = s; // [RULE6] [RULE13]
        end
        if (active[c]) begin
          aux_next[0] = aux_next[0] | t[2]; // [RULE4]
          aux_next[1] = aux_next[1] | (t[3] && !ctrl_reg[`INHIB_C_AUX2ALT_BIT]); // [RULE19]
          aux_next[2] = aux_next[2] | t[4]; // [RULE4]
        end
      end
    end
    // Switch options need the pin grounded together with throttle demand.
    fwd_next = !inh_fwd &&
               (!ctrl_reg[`INHIB_C_DIRSW_BIT] || (!stable_reg[0] && i_throttle_demand)) &&
               (!ctrl_reg[`INHIB_C_TILLER_BIT] || (!stable_reg[1] && i_throttle_demand)); // [RULE16] [RULE17]
    rev_next = !inh_rev &&
               (!ctrl_reg[`INHIB_C_TILLER_BIT] || (!stable_reg[1] && i_throttle_demand)); // [RULE17]
  end

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      o_fwd_allow   <= 1'b0;
      o_rev_allow   <= 1'b0;
      o_speed_cap   <= 7'h0;
      o_aux_inhibit <= 3'h0;
      o_aux2_switch <= 1'b0;
      o_trip_flash  <= 1'b0;
      o_trip_log    <= 1'b0;
    end else begin
      o_fwd_allow   <= fwd_next;
      o_rev_allow   <= rev_next;
      o_speed_cap   <= cap_next; // [RULE13]
      o_aux_inhibit <= aux_next;
      // Aux two follows input two only when targeted and not in alarm mode.
      o_aux2_switch <= active[1] && cfg_reg[1][`INHIB_F_TGT_LSB + 3] &&
                       !ctrl_reg[`INHIB_C_AUX2ALT_BIT]; // [RULE15] [RULE19]
      o_trip_flash  <= |latch_reg; // [RULE12]
      o_trip_log    <= |(trip_rise & ~latch_reg); // [RULE12]
    end
  end
endmodule : inhib_logic

// File: src/inhib_defines.svh
/*
  Register offsets, field positions, reset values and timing counts for the
  inhibit input block. Assumes a 250 MHz system clock and an APB register bus.
*/
`ifndef INHIB_DEFINES_SVH
`define INHIB_DEFINES_SVH

`define INHIB_CLK_HZ          250000000
`define INHIB_STEP_MS         500
`define INHIB_STEP_CYC        ((`INHIB_CLK_HZ / 1000) * `INHIB_STEP_MS)
`define INHIB_DFLT_DB_NS      1000000
`define INHIB_DFLT_DB_CYC     ((`INHIB_DFLT_DB_NS / 4))
`define INHIB_DB_MAX          4'h a
`define INHIB_SPD_MAX         7'h 64

`define INHIB_OFF_CFG0        12'h 000
`define INHIB_OFF_CFG1        12'h 004
`define INHIB_OFF_CTRL        12'h 008
`define INHIB_OFF_STAT        12'h 00c

`define INHIB_F_DB_LSB        0
`define INHIB_F_MODE_LSB      4
`define INHIB_F_TGT_LSB       8
`define INHIB_F_SPD_LSB       16
`define INHIB_F_OPL_BIT       24

`define INHIB_C_DIRSW_BIT     0
`define INHIB_C_TILLER_BIT    1
`define INHIB_C_AUX2ALT_BIT   2
`define INHIB_C_THR_BIT       3

`define INHIB_CFG_RST         32'h 0000_0000
`define INHIB_CTRL_RST        4'h 0
`endif

// File: src/inhib_pkg.sv
/*
  Types shared by the inhibit input block. Assumes the defines header for numbers.
*/
package inhib_pkg;
  typedef enum logic [1:0] {INHIB_MODE_OFF, INHIB_MODE_LOW, INHIB_MODE_OPEN,
                            INHIB_MODE_RSVD} inhib_mode_t;
  // Bit set of targets: forward, reverse, aux1, aux2, aux3.
  typedef enum logic [2:0] {INHIB_TGT_FWD, INHIB_TGT_REV, INHIB_TGT_AUX1,
                            INHIB_TGT_AUX2, INHIB_TGT_AUX3} inhib_tgt_bit_t;
endpackage : inhib_pkg

// File: bench/inhib_properties.sv
/* Port checker for inhib_logic.
   Assumes one clock domain and the asynchronous low reset. */
`timescale 1ns/1ps
module inhib_properties (
  input wire logic       i_clock,
  input wire logic       i_nrst,
  input wire logic       i_psel,
  input wire logic       i_penable,
  input wire logic       o_pready,
  input wire logic       o_pslverr,
  input wire logic [6:0] o_speed_cap,
  input wire logic       o_trip_flash,
  input wire logic       o_trip_log
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_nrst);
  sequence setup_s;
    i_psel && !i_penable;
  endsequence
  sequence answer_s;
    i_psel && i_penable && o_pready;
  endsequence
  chk_apb_answer: assert property (setup_s |=> answer_s)
    else $error("late ready");
  chk_ready_single: assert property (o_pready |=> !o_pready) else $error("long ready");
  chk_err_ready: assert property (o_pslverr |-> answer_s) else $error("stray error");
  chk_cap_range: assert property (o_speed_cap <= 7'h64) else $error("cap too big");
  chk_flash_held: assert property (o_trip_flash |=> o_trip_flash)
    else $error("flash lost");
  chk_log_pulse: assert property (o_trip_log |=> !o_trip_log) else $error("long log");
  chk_log_flash: assert property (o_trip_log |=> o_trip_flash) else $error("no flash");
  chk_flash_logged: assert property ($rose(o_trip_flash) |-> o_trip_log || $past(o_trip_log))
    else $error("flash not logged");
endmodule : inhib_properties

bind inhib_logic inhib_properties chk (.i_clock, .i_nrst, .i_psel, .i_penable, .o_pready,
  .o_pslverr, .o_speed_cap, .o_trip_flash, .o_trip_log);

// File: bench/inhib_switches.sv
/* Machine switches and throttle pedal.
   Assumes the bench sets the wanted levels just after a clock edge. */
`timescale 1ns/1ps
module inhib_switches (
  input  wire logic       i_clock,
  input  wire logic [1:0] i_want,
  input  wire logic       i_thr,
  output logic      [1:0] o_pin,
  output logic            o_thr
);
  logic [1:0] prev = 2'h3;
  logic [1:0] flip = 2'h0;
  logic [2:0] left = 3'h0;
  initial o_pin = 2'h3;
  initial o_thr = 1'b1;
  // Moved contacts chatter for a few cycles, so the filter is really exercised.
  always @(posedge i_clock) begin
    prev <= i_want;
    if (i_want != prev) begin
      flip <= i_want ^ prev;
      left <= 3'h5;
    end else if (left != 3'h0) begin
      left <= left - 3'h1;
    end
    o_pin <= i_want ^ (left[0] ? flip : 2'h0);
    o_thr <= i_thr;
  end
endmodule : inhib_switches

// File: bench/tb.sv
/* Bench for inhib_logic: APB set-up, switch stimulus, queued checks.
   Assumes the switch model and the bound checker. */
`timescale 1ns/1ps
module tb;
  logic        i_clock, i_nrst, i_psel, i_penable, i_pwrite, thr, snap;
  logic        i_throttle_demand, o_pready, o_pslverr, o_fwd_allow, o_rev_allow;
  logic        o_aux2_switch, o_trip_flash, o_trip_log;
  logic [11:0] i_paddr;
  logic [31:0] i_pwdata, o_prdata, r;
  logic [1:0]  want, i_pin;
  logic [6:0]  o_speed_cap;
  logic [2:0]  o_aux_inhibit;
  logic [4:0]  tg;
  logic [27:0] m, mq[$];
  logic [32:0] q[$];
  int          n_mismatch, cmp_count, n_log;
  wire  [13:0] ov = {o_trip_flash, o_aux2_switch, o_aux_inhibit, o_speed_cap,
                     o_fwd_allow, o_rev_allow};
  inhib_logic #(.STEP_CYC(20), .DFLT_CYC(4)) dut (.i_clock, .i_nrst, .i_psel, .i_penable,
    .i_pwrite, .i_paddr, .i_pwdata, .o_pready, .o_prdata, .o_pslverr, .i_pin,
    .i_throttle_demand, .o_fwd_allow, .o_rev_allow, .o_speed_cap, .o_aux_inhibit,
    .o_aux2_switch, .o_trip_flash, .o_trip_log);
  inhib_switches sw (.i_clock(i_clock), .i_want(want), .i_thr(thr), .o_pin(i_pin),
    .o_thr(i_throttle_demand));
  initial begin
    i_clock = 0;
    forever #2 i_clock = ~i_clock;
  end
  task automatic chk(input string nm, input logic [32:0] s, x);
    cmp_count++;
    if (s !== x) begin
      n_mismatch++;
      $display("BAD %s exp %h seen %h", nm, x, s);
    end
  endtask : chk
  task automatic test_done;
    if (n_mismatch == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : test_done
  task automatic step(input int n);
    repeat (n) @(posedge i_clock);
  endtask : step
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    i_psel <= 1;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_clock);
    i_penable <= 1;
    for (k = 0; k < 50; k++) begin
      @(posedge i_clock);
      if (o_pready === 1'b1) break;
    end
    if (k == 50) begin
      n_mismatch++;
      test_done();
    end
    i_psel <= 0;
    i_penable <= 0;
    @(posedge i_clock);
  endtask : apb
  task automatic rd(input logic [11:0] a, input logic [32:0] x);
    q.push_back(x);
    apb(1'b0, a, 32'h0);
  endtask : rd
  task automatic look(input logic [13:0] x, input logic [13:0] k = 14'h3fff);
    mq.push_back({k, x});
    snap <= 1;
    @(posedge i_clock);
    snap <= 0;
  endtask : look
  always @(posedge i_clock) begin
    if (o_trip_log === 1'b1) n_log++;
    if (i_psel && i_penable && o_pready === 1'b1 && !i_pwrite)
      chk("prdata", {o_pslverr, o_pslverr ? 32'h0 : o_prdata}, q.pop_front());
    if (snap) begin
      m = mq.pop_front();
      chk("outputs", {19'h0, ov & m[27:14]}, {19'h0, m[13:0] & m[27:14]});
    end
  end
  initial begin
    {i_nrst, i_psel, i_penable, i_pwrite, snap} = 5'h0;
    n_log = 0;
    i_paddr = 12'h0;
    i_pwdata = 32'h0;
    want = 2'h3;
    thr = 1;
    void'($urandom(28));
    step(8);
    i_nrst <= 1;
    step(1);
    rd(12'h000, 33'h0);
    rd(12'h00c, 33'h3);
    rd(12'h010, 33'h1_0000_0000);
    // A nonzero limit keeps a random set-up from latching a trip that only reset clears.
    r = {7'h0, 1'($urandom), 1'h0, 7'(1 + $urandom % 100), 3'h0, 5'($urandom), 2'h0,
         2'($urandom % 3), 4'($urandom % 11)};
    apb(1'b1, 12'h004, r);
    rd(12'h004, {1'h0, r});
    apb(1'b1, 12'h004, 32'h0);
    for (int j = 0; j < 3; j++) begin
      apb(1'b1, 12'h000, 32'h300 | 32'(j << 4));
      want <= 2'h2;
      step(20);
      look(j == 1 ? 14'h0190 : 14'h0193);
      want <= 2'h3;
      step(20);
      look(j == 2 ? 14'h0190 : 14'h0193);
    end
    for (int j = 0; j < 6; j++) begin
      tg = 5'h1 << j;
      apb(1'b1, 12'h000, 32'h10 | 32'(tg) << 8);
      want <= 2'h2;
      step(20);
      look({2'h0, tg[4:2], 7'h64, ~tg[0], ~tg[1]});
      want <= 2'h3;
      step(20);
    end
    // Latched bit set with a nonzero limit must be ignored.
    apb(1'b1, 12'h000, 32'h128_0310);
    want <= 2'h2;
    step(20);
    look(14'h00a3);
    want <= 2'h3;
    step(20);
    apb(1'b1, 12'h000, 32'h311);
    want <= 2'h2;
    step(14);
    look(14'h0193);
    step(26);
    look(14'h0190);
    apb(1'b1, 12'h000, 32'h0);
    apb(1'b1, 12'h004, 32'h810);
    want <= 2'h1;
    step(20);
    look(14'h1000, 14'h1000);
    apb(1'b1, 12'h008, 32'h4);
    look(14'h0000, 14'h1000);
    apb(1'b1, 12'h004, 32'h0);
    apb(1'b1, 12'h008, 32'h3);
    want <= 2'h0;
    step(20);
    look(14'h0193);
    thr <= 0;
    step(4);
    look(14'h0190);
    thr <= 1;
    want <= 2'h1;
    step(20);
    look(14'h0191);
    apb(1'b1, 12'h008, 32'h0);
    apb(1'b1, 12'h000, 32'h100_0310);
    want <= 2'h2;
    step(20);
    look(14'h2190);
    want <= 2'h3;
    step(20);
    look(14'h2190);
    chk("trip_log", n_log, 33'h1);
    i_nrst <= 0;
    step(8);
    i_nrst <= 1;
    step(20);
    look(14'h0193);
    test_done();
  end
endmodule : tb
